// ==== common/ddpu_pkg.sv ====
package ddpu_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PRI_LOW  = 10'h082;
  localparam logic [9:0] IDX_PRI_HIGH = 10'h083;
  localparam logic [9:0] IDX_AUX_LOW  = 10'h084;
  localparam logic [9:0] IDX_AUX_HIGH = 10'h085;
  localparam logic [9:0] IDX_CTRL     = 10'h086;

  // Field positions in pointer_select_control
  localparam int unsigned CTRL_AUX_DIR_BIT = 7;
  localparam int unsigned CTRL_PRI_DIR_BIT = 6;
  localparam int unsigned CTRL_TOGGLE_BIT  = 5;
  localparam int unsigned CTRL_AUTO_BIT    = 4;
  localparam int unsigned CTRL_SELECT_BIT  = 0;

  // Values after reset, fixed read values and pointer step size
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic        CTRL_BIT_RESET = 1'b0;
  localparam logic [2:0]  CTRL_RESV_VAL  = 3'h2;
  localparam logic [15:0] PTR_STEP       = 16'h0001;

  typedef enum logic [2:0] {
    DDPU_OP_INC,
    DDPU_OP_LOAD,
    DDPU_OP_CODE_RD,
    DDPU_OP_XDATA_RD,
    DDPU_OP_XDATA_WR
  } ddpu_op_t;

  typedef struct packed {
    logic        valid;
    ddpu_op_t    op;
    logic [15:0] imm;
  } ddpu_instr_t;

  typedef struct packed {
    logic aux_dir;
    logic pri_dir;
    logic toggle_on_use;
    logic auto_step_enable;
  } ddpu_mode_t;

  function automatic logic [15:0] ddpu_step_f(input logic [15:0] ptr, input logic down);
    logic [15:0] nxt;
    nxt = down ? (ptr - PTR_STEP) : (ptr + PTR_STEP);
    return nxt;
  endfunction : ddpu_step_f

  function automatic logic [7:0] ddpu_ctrl_byte_f(input ddpu_mode_t m, input logic sel);
    return {m.aux_dir, m.pri_dir, m.toggle_on_use, m.auto_step_enable, CTRL_RESV_VAL, sel};
  endfunction : ddpu_ctrl_byte_f

endpackage : ddpu_pkg

// ==== design/ddpu_instr_dec.sv ====
`timescale 1ns/1ps
module ddpu_instr_dec
  import ddpu_pkg::*;
(
  input  ddpu_instr_t instr,
  output logic        is_inc,
  output logic        is_load,
  output logic        is_move,
  output logic        is_ptr_op
);

  always_comb begin
    is_inc  = 1'b0;
    is_load = 1'b0;
    is_move = 1'b0;
    if (instr.valid) begin
      unique case (instr.op)
        DDPU_OP_INC: begin
          is_inc = 1'b1;
        end
        DDPU_OP_LOAD: begin
          is_load = 1'b1;
        end
        DDPU_OP_CODE_RD, DDPU_OP_XDATA_RD, DDPU_OP_XDATA_WR: begin
          is_move = 1'b1;
        end
        default: begin
          is_inc = 1'b0;
        end
      endcase
    end
    is_ptr_op = is_inc | is_load | is_move;
  end

endmodule : ddpu_instr_dec

// ==== design/ddpu_ptr_reg.sv ====
`timescale 1ns/1ps
module ddpu_ptr_reg
  import ddpu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  input  wire logic        step,
  input  wire logic        step_down,
  output logic      [15:0] ptr_q
);

  logic [15:0] ptr_d;

  // Instruction load and step win over a software byte write in the same cycle
  always_comb begin
    ptr_d = ptr_q;
    if (load) begin
      ptr_d = load_value;
    end else if (step) begin
      ptr_d = ddpu_step_f(ptr_q, step_down);
    end else begin
      if (wr_low) begin
        ptr_d[7:0] = wdata;
      end
      if (wr_high) begin
        ptr_d[15:8] = wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

endmodule : ddpu_ptr_reg

// ==== design/ddpu_top.sv ====
// Behaviour
// - Aux high byte register, read/write, resets zero
// - Select one: pointer instructions use auxiliary pointer
// - Bit 7 sets auxiliary step direction
// - Bit 6 sets primary step direction
// - Toggle bit inverts select after pointer instructions
// - Auto-step advances active pointer after moves
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ddpu_top
  import ddpu_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  ddpu_instr_t            instr,
  output logic      [15:0]       active_pointer,
  output logic      [15:0]       primary_pointer,
  output logic      [15:0]       auxiliary_pointer,
  output logic                   pointer_select
);

  ddpu_mode_t  mode_q;
  logic        select_q;
  logic [15:0] pri_q;
  logic [15:0] aux_q;
  logic [31:0] prdata_q;
  logic        err_q;
  logic [9:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        setup;
  logic        apb_wr;
  logic        wr_pri_low;
  logic        wr_pri_high;
  logic        wr_aux_low;
  logic        wr_aux_high;
  logic        wr_ctrl;
  logic        is_inc;
  logic        is_load;
  logic        is_move;
  logic        is_ptr_op;
  logic        step_req;
  logic [7:0]  rd_byte;

  ddpu_instr_dec u_dec (
    .instr     (instr),
    .is_inc    (is_inc),
    .is_load   (is_load),
    .is_move   (is_move),
    .is_ptr_op (is_ptr_op)
  );

  // APB decode; slave never inserts wait states
  assign idx     = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped  = aligned && ((idx == IDX_PRI_LOW) || (idx == IDX_PRI_HIGH) ||
                               (idx == IDX_AUX_LOW) || (idx == IDX_AUX_HIGH) ||
                               (idx == IDX_CTRL));
  assign setup   = psel && !penable;
  assign apb_wr  = psel && penable && pwrite && pready && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

  assign wr_pri_low  = apb_wr && (idx == IDX_PRI_LOW);
  assign wr_pri_high = apb_wr && (idx == IDX_PRI_HIGH);
  assign wr_aux_low  = apb_wr && (idx == IDX_AUX_LOW);
  assign wr_aux_high = apb_wr && (idx == IDX_AUX_HIGH);
  assign wr_ctrl     = apb_wr && (idx == IDX_CTRL);

  // Increment always steps; moves step only with auto-step on
  assign step_req = is_inc || (is_move && mode_q.auto_step_enable);

  ddpu_ptr_reg u_pri (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_low     (wr_pri_low),
    .wr_high    (wr_pri_high),
    .wdata      (pwdata[7:0]),
    .load       (is_load && !select_q),
    .load_value (instr.imm),
    .step       (step_req && !select_q),
    .step_down  (mode_q.pri_dir),
    .ptr_q      (pri_q)
  );

  ddpu_ptr_reg u_aux (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_low     (wr_aux_low),
    .wr_high    (wr_aux_high),
    .wdata      (pwdata[7:0]),
    .load       (is_load && select_q),
    .load_value (instr.imm),
    .step       (step_req && select_q),
    .step_down  (mode_q.aux_dir),
    .ptr_q      (aux_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '{CTRL_BIT_RESET, CTRL_BIT_RESET, CTRL_BIT_RESET, CTRL_BIT_RESET};
    end else if (wr_ctrl) begin
      mode_q.aux_dir          <= pwdata[CTRL_AUX_DIR_BIT];
      mode_q.pri_dir          <= pwdata[CTRL_PRI_DIR_BIT];
      mode_q.toggle_on_use    <= pwdata[CTRL_TOGGLE_BIT];
      mode_q.auto_step_enable <= pwdata[CTRL_AUTO_BIT];
    end
  end

  // Toggle from an instruction wins over a software write of the select bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_q <= CTRL_BIT_RESET;
    end else if (is_ptr_op && mode_q.toggle_on_use) begin
      select_q <= !select_q;
    end else if (wr_ctrl) begin
      select_q <= pwdata[CTRL_SELECT_BIT];
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (aligned) begin
      unique case (idx)
        IDX_PRI_LOW:  rd_byte = pri_q[7:0];
        IDX_PRI_HIGH: rd_byte = pri_q[15:8];
        IDX_AUX_LOW:  rd_byte = aux_q[7:0];
        IDX_AUX_HIGH: rd_byte = aux_q[15:8];
        IDX_CTRL:     rd_byte = ddpu_ctrl_byte_f(mode_q, select_q);
        default:      rd_byte = 8'h00;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
      err_q    <= !mapped;
    end
  end

  assign prdata            = prdata_q;
  assign primary_pointer   = pri_q;
  assign auxiliary_pointer = aux_q;
  assign pointer_select    = select_q;
  assign active_pointer    = select_q ? aux_q : pri_q;

  chk_aux_high_write:
    assert property (@(posedge pclk) disable iff (!presetn)
      (wr_aux_high && !(instr.valid && select_q))
      |=> (aux_q[15:8] == $past(pwdata[7:0])))
    else $error("aux high byte not written");

  chk_aux_inc_sel:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_inc && select_q && !mode_q.aux_dir)
      |=> (aux_q == 16'($past(aux_q) + PTR_STEP)) && (pri_q == $past(pri_q)))
    else $error("selected aux pointer not incremented alone");

  chk_pri_load_sel:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_load && !select_q)
      |=> (pri_q == $past(instr.imm)) && (aux_q == $past(aux_q)))
    else $error("primary pointer load wrong");

  chk_aux_dec_dir:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_inc && select_q && mode_q.aux_dir)
      |=> (aux_q == 16'($past(aux_q) - PTR_STEP)))
    else $error("aux pointer not decremented");

  chk_pri_step_dir:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_inc && !select_q)
      |=> (pri_q == ($past(mode_q.pri_dir) ? 16'($past(pri_q) - PTR_STEP)
                                           : 16'($past(pri_q) + PTR_STEP))))
    else $error("primary pointer step direction wrong");

  chk_toggle_select:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_ptr_op && mode_q.toggle_on_use) |=> (select_q != $past(select_q)))
    else $error("select not toggled");

  chk_hold_select:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_q.toggle_on_use && !wr_ctrl) |=> $stable(select_q))
    else $error("select changed without cause");

  chk_auto_step_move:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_move && !select_q) |=>
      (pri_q == ($past(mode_q.auto_step_enable)
                 ? ddpu_step_f($past(pri_q), $past(mode_q.pri_dir)) : $past(pri_q))))
    else $error("auto-step of primary pointer wrong");

  chk_step_before_toggle:
    assert property (@(posedge pclk) disable iff (!presetn)
      (is_move && select_q && mode_q.auto_step_enable && mode_q.toggle_on_use)
      |=> !select_q && (aux_q == ddpu_step_f($past(aux_q), $past(mode_q.aux_dir)))
          && (pri_q == $past(pri_q)))
    else $error("step not applied to old pointer");

  cov_toggle_use:
    cover property (@(posedge pclk) disable iff (!presetn)
      (is_ptr_op && mode_q.toggle_on_use) ##1 (is_ptr_op && mode_q.toggle_on_use));

  cov_auto_step:
    cover property (@(posedge pclk) disable iff (!presetn)
      is_move && mode_q.auto_step_enable && select_q);

  cov_ctrl_read:
    cover property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && (idx == IDX_CTRL));

  cov_unmapped:
    cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : ddpu_top

// ==== verification/ddpu_core_model.sv ====
`timescale 1ns/1ps
module ddpu_core_model
  import ddpu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  ddpu_op_t         op,
  input  wire logic [15:0] imm,
  output ddpu_instr_t      instr
);
  // One-cycle pulse per instruction; idle immediate keeps changing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= '0;
    end else if (go) begin
      instr <= '{valid: 1'b1, op: op, imm: imm};
    end else begin
      instr <= '{valid: 1'b0, op: instr.op, imm: ~instr.imm};
    end
  end
endmodule : ddpu_core_model

// ==== verification/ddpu_top_tb_top.sv ====
`timescale 1ns/1ps
module ddpu_top_tb_top
  import ddpu_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ddpu_instr_t       instr;
  logic [15:0]       active_pointer;
  logic              go;
  ddpu_op_t          op;
  logic [15:0]       imm;
  logic              ap_pend;
  logic [32:0]       rd_q[$];
  logic [15:0]       ap_q[$];
  logic [15:0]       m_pri;
  logic [15:0]       m_aux;
  logic              m_sel;
  logic [3:0]        m_mode;
  int                err_count;
  int                check_count;
  int                cyc;
  integer            seed;

  ddpu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr(instr), .active_pointer(active_pointer),
    .primary_pointer(), .auxiliary_pointer(), .pointer_select());
  ddpu_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .op(op), .imm(imm),
    .instr(instr));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic conclude();
    $display("counts checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch apb_read exp %h got %h", e, g);
    end
  endtask : cmp_rd

  task automatic cmp_ap(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch active_pointer exp %h got %h", e, g);
    end
  endtask : cmp_ap

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      cmp_rd(rd_q.pop_front(), {pslverr, prdata});
    end
    if (ap_pend === 1'b1) begin
      cmp_ap(ap_q.pop_front(), active_pointer);
    end
    ap_pend <= instr.valid;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 6000) begin
      err_count++;
      conclude();
    end
  end

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    case (idx)
      IDX_PRI_LOW:  m_pri[7:0] = wd;
      IDX_PRI_HIGH: m_pri[15:8] = wd;
      IDX_AUX_LOW:  m_aux[7:0] = wd;
      IDX_AUX_HIGH: m_aux[15:8] = wd;
      IDX_CTRL: begin
        m_mode = wd[7:4];
        m_sel = wd[0];
      end
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    logic [32:0] e;
    case (idx)
      IDX_PRI_LOW:  e = {25'h0, m_pri[7:0]};
      IDX_PRI_HIGH: e = {25'h0, m_pri[15:8]};
      IDX_AUX_LOW:  e = {25'h0, m_aux[7:0]};
      IDX_AUX_HIGH: e = {25'h0, m_aux[15:8]};
      IDX_CTRL:     e = {25'h0, m_mode, 3'b010, m_sel};
      default:      e = {1'b1, 32'h0000_0000};
    endcase
    rd_q.push_back(e);
    apb(1'b0, idx, 8'h5a);
  endtask : rd

  task automatic ins(input ddpu_op_t o, input logic [15:0] v);
    logic [15:0] p;
    logic        d;
    p = m_sel ? m_aux : m_pri;
    d = m_sel ? m_mode[3] : m_mode[2];
    if (o == DDPU_OP_LOAD) p = v;
    else if (o == DDPU_OP_INC || m_mode[0]) p = d ? p - 16'h0001 : p + 16'h0001;
    if (m_sel) m_aux = p;
    else m_pri = p;
    if (m_mode[1]) m_sel = ~m_sel;
    ap_q.push_back(m_sel ? m_aux : m_pri);
    @(posedge pclk);
    go <= 1'b1;
    op <= o;
    imm <= v;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask : ins

  initial begin
    int r;
    {psel, penable, pwrite, go, ap_pend, m_sel} = '0;
    {paddr, pwdata, imm, m_pri, m_aux, m_mode} = '0;
    op = DDPU_OP_INC;
    {err_count, check_count, cyc} = '0;
    seed = 92;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (logic [9:0] i = IDX_PRI_LOW; i <= 10'h087; i++) rd(i);
    $display("test reset_values done");
    for (logic [9:0] i = IDX_PRI_LOW; i <= 10'h087; i++) begin
      r = $random(seed);
      wr(i, r[7:0]);
      rd(i);
    end
    $display("test register_access done");
    for (int m = 0; m < 32; m++) begin
      r = $random(seed);
      wr(IDX_CTRL, {m[4:1], 3'b111, m[0]});
      ins(DDPU_OP_LOAD, m[1] ? 16'h0000 : r[15:0]);
      for (int o = 0; o < 5; o++) begin
        r = $random(seed);
        ins(ddpu_op_t'(o), r[15:0]);
      end
      for (logic [9:0] i = IDX_PRI_LOW; i <= IDX_CTRL; i++) rd(i);
    end
    $display("test pointer_ops done");
    conclude();
  end
endmodule : ddpu_top_tb_top
